//--- pmc_pkg.sv
// shared types and constants for the privilege mode control block
package pmc_pkg;
	localparam int REG_W = 32;
	localparam int REG_CNT = 16;
	localparam logic [3:0] SP_IDX = 4'hD;
	localparam int CTRL_USER_BIT = 0;
	localparam int CTRL_STK_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [REG_W-1:0] SP_RST = 32'h00000000;
	localparam logic [REG_W-1:0] SP_ALIGN_MASK = 32'hFFFFFFFC;

	// access class of the instruction being executed
	typedef struct packed {
		logic valid;
		logic priv_only;
		logic ctrl_wr;
		logic [1:0] ctrl_data;
	} pmc_req_t;

	// core register write port
	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [REG_W-1:0] data;
	} pmc_wr_t;

	typedef enum logic [1:0] {PMC_PRIV_THREAD, PMC_USER_THREAD, PMC_PRIV_HANDLER} pmc_state_t;
endpackage

//--- pmc_regfile.sv
// sixteen-word core register file with banked stack pointer
`timescale 1ns/1ps
module pmc_regfile #(
	parameter int W = pmc_pkg::REG_W,
	parameter int N = pmc_pkg::REG_CNT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire pmc_pkg::pmc_wr_t wr,
	input wire logic use_psp,
	input wire logic [3:0] rd_idx,
	output logic [W-1:0] rd_data,
	output logic [W-1:0] main_stack_pointer,
	output logic [W-1:0] process_stack_pointer
);
	import pmc_pkg::*;
	logic [W-1:0] regs_r [N];
	logic [W-1:0] regs_nxt [N];
	logic [W-1:0] msp_r, msp_nxt, psp_r, psp_nxt;

	// writes to r13 land in whichever stack pointer is active
	always_comb begin
		regs_nxt = regs_r;
		msp_nxt = msp_r;
		psp_nxt = psp_r;
		if (wr.en) begin
			if (wr.idx == SP_IDX) begin
				if (use_psp) begin // RQ10
					psp_nxt = wr.data & SP_ALIGN_MASK;
				end else begin
					msp_nxt = wr.data & SP_ALIGN_MASK;
				end
			end else begin
				regs_nxt[wr.idx] = wr.data; // RQ7
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				regs_r[i] <= '0;
			end
			msp_r <= SP_RST;
			psp_r <= SP_RST;
		end else begin
			regs_r <= regs_nxt;
			msp_r <= msp_nxt; // RQ6
			psp_r <= psp_nxt;
		end
	end

	// read data registered, as data outputs come from flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (rd_idx == SP_IDX) begin
			rd_data <= use_psp ? psp_nxt : msp_nxt;
		end else begin
			rd_data <= regs_nxt[rd_idx];
		end
	end

	assign main_stack_pointer = msp_r;
	assign process_stack_pointer = psp_r;
endmodule

//--- pmc_mode_ctrl.sv
// privilege level and execution mode tracker with stack select and access fault
`timescale 1ns/1ps
// Behaviour
// (RQ1) handler mode exists only at the privileged level, so only three states are legal.
// (RQ2) at user level a restricted access is blocked and raises a fault.
// (RQ3) at privileged level every access is allowed with no privilege fault.
// (RQ4) exception service runs in privileged handler mode, otherwise thread mode.
// (RQ5) a privileged-only instruction decoded at user level does not complete and faults.
// (RQ6) two separate stack pointers, main and process, are kept.
// (RQ7) the sixteen core registers are each 32 bits wide.
// (RQ8) control bit 0 selects privileged (0) or user (1) thread mode.
// (RQ9) control bit 1 selects main (0) or process (1) stack and reads 0 in handler mode.
// (RQ10) the process stack is used only at user level in thread mode.
// (RQ11) reset gives privileged thread mode, main stack and control cleared.
module pmc_mode_ctrl (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic exc_entry,
	input wire logic exc_return,
	input wire pmc_pkg::pmc_req_t req,
	input wire pmc_pkg::pmc_wr_t reg_wr,
	input wire logic [3:0] rd_idx,
	output logic [pmc_pkg::REG_W-1:0] rd_data,
	output logic [pmc_pkg::REG_W-1:0] main_stack_pointer,
	output logic [pmc_pkg::REG_W-1:0] process_stack_pointer,
	output logic [1:0] ctrl_value,
	output pmc_pkg::pmc_state_t state,
	output logic handler_mode,
	output logic user_level,
	output logic use_psp,
	output logic grant,
	output logic fault
);
	import pmc_pkg::*;
	pmc_state_t state_r, state_nxt;
	logic [1:0] ctrl_r, ctrl_nxt;
	logic fault_r, fault_nxt;
	logic blocked;
	pmc_wr_t wr_gated;

	// a restricted request at user level is blocked; privileged level never blocks
	assign blocked = req.valid && req.priv_only && (state_r == PMC_USER_THREAD); // RQ2 RQ3 RQ5
	assign grant = req.valid && !blocked;

	// level and mode transitions; handler is entered only as privileged
	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		fault_nxt = blocked; // RQ2
		if (exc_entry) begin
			state_nxt = PMC_PRIV_HANDLER; // RQ4 RQ1
		end else if (exc_return && state_r == PMC_PRIV_HANDLER) begin
			state_nxt = ctrl_r[CTRL_USER_BIT] ? PMC_USER_THREAD : PMC_PRIV_THREAD; // RQ4 RQ8
		end else if (req.valid && req.ctrl_wr && !blocked) begin
			// blocked writes never reach control; a user write without priv_only can still regain privilege
			ctrl_nxt = req.ctrl_data;
			if (state_r == PMC_PRIV_HANDLER) begin
				ctrl_nxt[CTRL_STK_BIT] = 1'b0; // RQ9
			end else begin
				state_nxt = req.ctrl_data[CTRL_USER_BIT] ? PMC_USER_THREAD : PMC_PRIV_THREAD; // RQ8
			end
		end
		case (state_nxt)
			PMC_PRIV_THREAD, PMC_USER_THREAD, PMC_PRIV_HANDLER: begin
			end
			default: begin
				state_nxt = PMC_PRIV_THREAD; // RQ1
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= PMC_PRIV_THREAD; // RQ11
			ctrl_r <= CTRL_RST;
			fault_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			fault_r <= fault_nxt;
		end
	end

	// stack choice: process stack only for user thread with bit 1 set
	assign use_psp = (state_r == PMC_USER_THREAD) && ctrl_r[CTRL_STK_BIT]; // RQ10 RQ9
	assign handler_mode = (state_r == PMC_PRIV_HANDLER);
	assign user_level = (state_r == PMC_USER_THREAD);
	assign ctrl_value = handler_mode ? {1'b0, ctrl_r[CTRL_USER_BIT]} : ctrl_r; // RQ9
	assign state = state_r;
	assign fault = fault_r;

	// a blocked instruction must not retire its register write
	always_comb begin
		wr_gated = reg_wr;
		wr_gated.en = reg_wr.en && !blocked; // RQ5
	end

	pmc_regfile #(.W(REG_W), .N(REG_CNT)) u_regs (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr(wr_gated),
		.use_psp(use_psp),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.main_stack_pointer(main_stack_pointer),
		.process_stack_pointer(process_stack_pointer)
	);
endmodule

//--- pmc_mode_ctrl_asserts.sv
// assertion checker for the mode control block
`timescale 1ns/1ps
module pmc_mode_ctrl_asserts import pmc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic exc_entry,
	input wire pmc_pkg::pmc_req_t req,
	input wire logic [1:0] ctrl_value,
	input wire logic handler_mode,
	input wire logic user_level,
	input wire logic use_psp,
	input wire logic grant,
	input wire logic fault
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// restricted request seen at user level
	wire blk = req.valid && req.priv_only && user_level;
	a_no_user_hdl: assert property (!(handler_mode && user_level)) else $error("user handler");
	a_user_block: assert property (blk |-> !grant) else $error("granted");
	a_fault_next: assert property (blk && !exc_entry |=> fault) else $error("no fault");
	a_priv_grant: assert property (req.valid && !user_level |-> grant) else $error("refused");
	a_entry_hdl: assert property (exc_entry |=> handler_mode) else $error("no handler");
	a_psp_user: assert property (use_psp |-> user_level && !handler_mode) else $error("bad stack");
	a_hdl_stk: assert property (handler_mode |-> !ctrl_value[1]) else $error("stack bit set");
	a_thread_lvl: assert property (!handler_mode |-> user_level == ctrl_value[0]) else $error("level");
endmodule

//--- pmc_core_model.sv
// core exception sequencer making entry and return pulses
`timescale 1ns/1ps
module pmc_core_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic handler_mode,
	output logic exc_entry,
	output logic exc_return
);
	// a return is only sent while a handler runs, as the real core does
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			exc_entry <= 1'h0;
			exc_return <= 1'h0;
		end else begin
			exc_entry <= en && !handler_mode && !exc_entry && $urandom % 4 == 0;
			exc_return <= en && handler_mode && !exc_return && $urandom % 4 == 0;
		end
	end
endmodule

//--- test_privilege_mode_control.sv
// self-checking bench for the privilege mode control block
`timescale 1ns/1ps
module test_privilege_mode_control;
	import pmc_pkg::*;
	logic core_clk = 1'h0, rst_n = 1'h0, en = 1'h0, exc_entry, exc_return;
	pmc_req_t req = '0;
	pmc_wr_t reg_wr = '0;
	logic [3:0] rd_idx = SP_IDX;
	logic [REG_W-1:0] rd_data, main_stack_pointer, process_stack_pointer, d;
	logic [1:0] ctrl_value;
	pmc_state_t state;
	logic handler_mode, user_level, use_psp, grant, fault;
	int n_mismatch = 0, compares = 0;
	// restricted request seen at user level in the cycle just before
	logic blk_prev = 1'h0;
	pmc_mode_ctrl dut_u (.*);
	pmc_core_model core_u (.*);
	// free-running core clock
	initial forever #5 core_clk = ~core_clk;
	function automatic logic [REG_W-1:0] sp_exp(input logic [REG_W-1:0] v);
		return v & SP_ALIGN_MASK;
	endfunction
	task automatic chk(input logic ok);
		compares++;
		if (ok !== 1'h1) begin
			n_mismatch++;
			$display("ERROR %0t check %0d", $time, compares);
		end
	endtask
	task automatic final_report();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// drive one request at the edge, then let it land
	task automatic cyc(input pmc_req_t r, input pmc_wr_t w);
		@(posedge core_clk);
		req <= r;
		reg_wr <= w;
		#1;
	endtask
	// bounded wait on the mode, a hang ends the run
	task automatic wait_hdl(input logic v);
		for (int i = 0; handler_mode !== v; i++) begin
			if (i == 100) begin
				chk(1'h0);
				final_report();
			end
			cyc(req, reg_wr);
		end
	endtask
	// directed corner cases, then random traffic
	initial begin
		void'($urandom(86));
		repeat (8) @(posedge core_clk);
		chk(state === PMC_PRIV_THREAD && ctrl_value === CTRL_RST && !use_psp);
		rst_n <= 1'h1;
		d = $urandom;
		cyc(5'h10, {1'h1, SP_IDX, d});
		cyc(5'h17, '0);
		chk(main_stack_pointer === sp_exp(d) && rd_data === sp_exp(d) && grant);
		cyc(5'h10, {1'h1, SP_IDX, ~d});
		chk(user_level === 1'h1 && use_psp === 1'h1);
		cyc(5'h1C, {1'h1, SP_IDX, d});
		chk(grant === 1'h0 && process_stack_pointer === sp_exp(~d));
		cyc(5'h00, '0);
		chk(fault === 1'h1 && process_stack_pointer === sp_exp(~d) && user_level);
		$display("directed done");
		en = 1'h1;
		wait_hdl(1'h1);
		chk(state === PMC_PRIV_HANDLER && !use_psp && ctrl_value === 2'h1);
		wait_hdl(1'h0);
		en = 1'h0;
		chk(state === PMC_USER_THREAD);
		$display("exception done");
		repeat (300) begin
			en <= 1'($urandom);
			cyc(5'($urandom), {1'($urandom), 4'($urandom), 32'($urandom)});
			chk(fault === blk_prev);
			chk(grant === (req.valid && !(req.priv_only && user_level)));
			chk(!(handler_mode === 1'h1 && user_level === 1'h1));
			blk_prev = req.valid && req.priv_only && user_level;
		end
		$display("random done");
		final_report();
	end
endmodule
bind pmc_mode_ctrl pmc_mode_ctrl_asserts chk_u (.*);
